// ---- core/opmode_pkg.sv ----
/*
  shared constants and carrier types for the operating-mode controller.
  assumes a 100 MHz core clock, the only timebase the block has.
*/
package opmode_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLK_MHZ      = 100;  // core clock rate
  localparam int ACT_INIT_US  = 10;   // start delay from active
  localparam int STBY_INIT_US = 35;   // start delay from standby
  localparam logic [31:0] ACT_INIT_CYC  = 32'(ACT_INIT_US * CLK_MHZ);
  localparam logic [31:0] STBY_INIT_CYC = 32'(STBY_INIT_US * CLK_MHZ);
  localparam logic [31:0] CONV_BASE_CYC = 32'h0000_0064; // one axis, no averaging
  localparam logic [31:0] SELFTEST_CYC  = 32'h0000_00c8; // one self-test pass

  // ****************************************
  // register offsets
  // ****************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_SENSOR = 8'h04;
  localparam logic [7:0] A_WAKE   = 8'h08;
  localparam logic [7:0] A_ALERT  = 8'h0c;
  localparam logic [7:0] A_TRIG   = 8'h10;
  localparam logic [7:0] A_STATUS = 8'h14;
  localparam logic [7:0] A_RESULT = 8'h18;

  // ****************************************
  // field encodings
  // ****************************************
  localparam logic [2:0] OM_CFG   = 3'h0;
  localparam logic [2:0] OM_STBY  = 3'h1;
  localparam logic [2:0] OM_ACTC  = 3'h2; // active, continuous
  localparam logic [2:0] OM_ACTT  = 3'h3; // active, triggered
  localparam logic [2:0] OM_WSLP  = 3'h4;
  localparam logic [2:0] OM_SLEEP = 3'h5;
  localparam logic [2:0] OM_DEEP  = 3'h6;
  localparam logic [1:0] TS_REG   = 2'h0; // trigger register write
  localparam logic [1:0] TS_CS    = 2'h1; // chip select falling edge
  localparam logic [1:0] TS_ALERT = 2'h2; // alert pin pulled low

  // ****************************************
  // carriers and reset values
  // ****************************************
  typedef struct packed {
    logic [1:0] trig_src;
    logic [2:0] op_mode;
  } ctrl_t;
  typedef struct packed {
    logic       selftest_enable;
    logic [1:0] selftest_schedule;
    logic [2:0] sample_averaging;
    logic [3:0] axis_channel_enable;
  } sensor_cfg_t;
  typedef struct packed {
    logic thr_only;
    logic on_done;
  } alert_cfg_t;
  localparam ctrl_t       CTRL_RST   = '{trig_src: 2'h0, op_mode: 3'h0};
  localparam sensor_cfg_t SENSOR_RST = 10'h001;
  localparam logic [3:0]  WAKE_RST   = 4'h0;
  localparam alert_cfg_t  ALERT_RST  = 2'h0;

endpackage

// ---- core/delay_timer.sv ----
/*
  down-counting delay timer with a one-cycle done pulse.
  assumes load and abort come from logic on the same clock.
*/
module delay_timer #(
  parameter int W = 32
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // control
  input  wire logic         load,
  input  wire logic         abort,
  input  wire logic [W-1:0] value,
  // status
  output logic              busy,
  output logic              done
);

  logic [W-1:0] count_r; // cycles left, zero when idle

  // count down; load wins over abort so a restart is never lost
  always_ff @(posedge clk) begin
    if (!rstn) begin
      count_r <= '0;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      if (load) begin
        count_r <= (value == '0) ? W'(1) : value; // at least one cycle
      end else if (abort) begin
        count_r <= '0;
      end else if (count_r != '0) begin
        count_r <= count_r - W'(1);
        done    <= (count_r == W'(1));
      end
    end
  end

  assign busy = (count_r != '0);

endmodule

// ---- core/link_sync.sv ----
/*
  two-flop synchronisers with edge detection for pins from the serial link.
  assumes the pins are asynchronous to clk; idle levels are a parameter.
*/
module link_sync #(
  parameter int         N    = 3,
  parameter logic [2:0] IDLE = 3'h0
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // raw pins
  input  wire logic [N-1:0] din,
  // synchronised levels and edges
  output logic [N-1:0]      level,
  output logic [N-1:0]      rise,
  output logic [N-1:0]      fall
);

  logic [N-1:0] s1_r; // metastable stage, read by s2_r only
  logic [N-1:0] s2_r; // settled level
  logic [N-1:0] s3_r; // previous settled level

  // one chain per pin
  for (genvar i = 0; i < N; i++) begin : g_bit
    always_ff @(posedge clk) begin
      if (!rstn) begin
        s1_r[i] <= IDLE[i];
        s2_r[i] <= IDLE[i];
        s3_r[i] <= IDLE[i];
      end else begin
        s1_r[i] <= din[i];
        s2_r[i] <= s1_r[i];
        s3_r[i] <= s2_r[i];
      end
    end
    assign rise[i] = s2_r[i] & ~s3_r[i];
    assign fall[i] = ~s2_r[i] & s3_r[i];
  end

  assign level = s2_r;

endmodule

// ---- core/opmode_ctrl.sv ----
/*
  operating-mode controller of a three-axis magnetic sensor: mode states,
  start delays, conversion timing, periodic wake-up and the alert pin.
  assumes a register port decoded from the serial link on the same clock,
  raw serial pins, and a threshold flag from the result path on clk.
*/
module opmode_ctrl #(
  parameter int MS_CYC        = 100000, // core cycles per millisecond
  parameter int CFG_STBY_CYC  = 5000,   // cfg_to_standby_time in cycles
  parameter int SLEEP_EXIT_CYC = 5000   // sleep exit time in cycles
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata,
  // serial link pins
  input  wire logic        cs_n,
  input  wire logic        sck,
  // open-drain alert pin
  input  wire logic        alert_i,
  output logic             alert_o,
  output logic             alert_oe,
  // result path
  input  wire logic        thr_exceeded,
  // status to the analog side
  output logic [2:0]       mode_code,
  output logic             support_on,
  output logic             conv_start,
  output logic             conv_busy
);

  // ****************************************
  // types and state
  // ****************************************
  typedef enum logic [2:0] {S_CFG, S_STBY, S_ACT, S_WSLP, S_SLEEP, S_DEEP, S_EXIT} state_t;
  typedef enum logic [1:0] {C_IDLE, C_INIT, C_RUN} conv_t;

  state_t                    state_r;   // operating mode
  conv_t                     conv_r;    // conversion phase
  opmode_pkg::ctrl_t         ctrl_r;    // mode and trigger source
  opmode_pkg::sensor_cfg_t   sensor_r;  // conversion setup
  logic [3:0]                wake_r;    // wake interval select
  opmode_pkg::alert_cfg_t    alrt_r;    // alert setup
  logic [15:0]               result_r;  // completed conversion count
  logic [3:0]                own_r;     // recent own alert drive history

  // ****************************************
  // helper functions
  // ****************************************

  // mode field to state; unknown codes fall back to configuration
  function automatic state_t target(input logic [2:0] om);
    unique case (om)
      opmode_pkg::OM_STBY:  target = S_STBY;
      opmode_pkg::OM_ACTC,
      opmode_pkg::OM_ACTT:  target = S_ACT;
      opmode_pkg::OM_WSLP:  target = S_WSLP;
      opmode_pkg::OM_SLEEP: target = S_SLEEP;
      opmode_pkg::OM_DEEP:  target = S_DEEP;
      default:              target = S_CFG;
    endcase
  endfunction

  // start delay depends on where the conversion starts from
  function automatic logic [31:0] init_delay(input state_t s);
    unique case (s)
      S_ACT:   init_delay = opmode_pkg::ACT_INIT_CYC;
      S_STBY:  init_delay = opmode_pkg::STBY_INIT_CYC;
      S_CFG:   init_delay = 32'(CFG_STBY_CYC) + opmode_pkg::STBY_INIT_CYC;
      default: init_delay = 32'(SLEEP_EXIT_CYC) + 32'(CFG_STBY_CYC)
                            + opmode_pkg::STBY_INIT_CYC;
    endcase
  endfunction

  // conversion length from channel count, averaging and self-test
  function automatic logic [31:0] conv_len(input opmode_pkg::sensor_cfg_t c);
    logic [31:0] n;
    logic [31:0] len;
    n = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      n = n + 32'(c.axis_channel_enable[i]);
    end
    if (n == 32'h0000_0000) begin
      n = 32'h0000_0001; // nothing enabled still takes one slot
    end
    len = n * (opmode_pkg::CONV_BASE_CYC << c.sample_averaging);
    if (c.selftest_enable) begin
      len = len + (opmode_pkg::SELFTEST_CYC << c.selftest_schedule);
    end
    conv_len = len;
  endfunction

  // wake interval table in milliseconds
  function automatic logic [31:0] wake_ms(input logic [3:0] sel);
    unique case (sel)
      4'h0:    wake_ms = 32'h0000_0001;
      4'h1:    wake_ms = 32'h0000_0005;
      4'h2:    wake_ms = 32'h0000_000a;
      4'h3:    wake_ms = 32'h0000_000f;
      4'h4:    wake_ms = 32'h0000_0014;
      4'h5:    wake_ms = 32'h0000_001e;
      4'h6:    wake_ms = 32'h0000_0064;
      4'h7:    wake_ms = 32'h0000_01f4;
      default: wake_ms = 32'h0000_03e8;
    endcase
  endfunction

  // reported mode code; the exit phase shows as configuration
  function automatic logic [2:0] code_of(input state_t s, input logic [2:0] om);
    unique case (s)
      S_STBY:  code_of = opmode_pkg::OM_STBY;
      S_ACT:   code_of = om;
      S_WSLP:  code_of = opmode_pkg::OM_WSLP;
      S_SLEEP: code_of = opmode_pkg::OM_SLEEP;
      S_DEEP:  code_of = opmode_pkg::OM_DEEP;
      default: code_of = opmode_pkg::OM_CFG;
    endcase
  endfunction

  // ****************************************
  // link pins
  // ****************************************
  logic [2:0] pin_lvl;  // synced {alert, sck, cs_n}
  logic [2:0] pin_rise; // rising edges
  logic [2:0] pin_fall; // falling edges

  // idle levels: alert high, sck low, cs_n high
  link_sync #(.N(3), .IDLE(3'h5)) u_sync (
    .clk   (clk),
    .rstn  (rstn),
    .din   ({alert_i, sck, cs_n}),
    .level (pin_lvl),
    .rise  (pin_rise),
    .fall  (pin_fall)
  );

  // our own drive shows up late through the synchroniser, so mask it
  logic alert_ext; // host pulled alert low
  assign alert_ext = pin_fall[2] & ~(|own_r) & ~alert_oe;

  logic spi_act;   // chip select or clock activity
  assign spi_act = pin_fall[0] | (pin_rise[1] & ~pin_lvl[0]);

  // ****************************************
  // events
  // ****************************************
  logic asleep;     // any of the sleep states
  logic awake;      // register writes allowed
  logic wake_evt;   // host wakes a sleeping device
  logic mode_chg;   // field asks for a new mode
  logic trig_evt;   // trigger by the selected source
  logic trig_ok;    // current mode accepts triggers
  logic start_req;  // begin a start delay
  logic ph_done;    // phase timer expired
  logic ph_load;    // phase timer reload
  logic [31:0] ph_val;
  logic wk_done;    // wake interval expired
  logic wk_load;    // wake interval reload
  logic deep_entry; // moving into deep sleep

  assign asleep   = (state_r == S_WSLP) | (state_r == S_SLEEP) | (state_r == S_DEEP);
  assign awake    = (state_r == S_CFG) | (state_r == S_STBY) | (state_r == S_ACT);
  assign wake_evt = asleep & (spi_act | alert_ext);
  assign mode_chg = awake & (target(ctrl_r.op_mode) != state_r);
  assign deep_entry = mode_chg & (target(ctrl_r.op_mode) == S_DEEP);

  // trigger source selection
  always_comb begin
    unique case (ctrl_r.trig_src)
      opmode_pkg::TS_CS:    trig_evt = pin_fall[0];
      opmode_pkg::TS_ALERT: trig_evt = alert_ext;
      default:              trig_evt = wr & (addr == opmode_pkg::A_TRIG);
    endcase
  end

  // deep sleep and plain sleep never take a trigger
  assign trig_ok = (state_r == S_STBY) | (state_r == S_CFG)
                 | ((state_r == S_ACT) & (ctrl_r.op_mode == opmode_pkg::OM_ACTT));

  assign start_req = (conv_r == C_IDLE) & ~mode_chg & (
                       (trig_ok & trig_evt)
                     | ((state_r == S_ACT) & (ctrl_r.op_mode == opmode_pkg::OM_ACTC))
                     | ((state_r == S_WSLP) & wk_done & ~wake_evt));

  // ****************************************
  // timers, all counted on clk
  // ****************************************
  always_comb begin
    ph_load = 1'b0;
    ph_val  = 32'h0000_0000;
    if (wake_evt) begin
      ph_load = 1'b1;
      ph_val  = 32'(SLEEP_EXIT_CYC);
    end else if (start_req) begin
      ph_load = 1'b1;
      ph_val  = init_delay(state_r);
    end else if ((conv_r == C_INIT) & ph_done) begin
      ph_load = 1'b1;
      ph_val  = conv_len(sensor_r);
    end
  end

  // one timer covers exit, start delay and conversion: they never overlap
  delay_timer #(.W(32)) u_phase (
    .clk   (clk),
    .rstn  (rstn),
    .load  (ph_load),
    .abort (mode_chg),
    .value (ph_val),
    .busy  (),
    .done  (ph_done)
  );

  assign wk_load = (mode_chg & (target(ctrl_r.op_mode) == S_WSLP))
                 | ((state_r == S_WSLP) & wk_done);

  // periodic wake interval
  delay_timer #(.W(32)) u_wake (
    .clk   (clk),
    .rstn  (rstn),
    .load  (wk_load),
    .abort (state_r != S_WSLP),
    .value (32'(wake_ms(wake_r) * 32'(MS_CYC))),
    .busy  (),
    .done  (wk_done)
  );

  // ****************************************
  // operating mode
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_r <= S_CFG;
    end else begin
      unique case (state_r)
        S_CFG, S_STBY, S_ACT: begin
          if (mode_chg) begin
            state_r <= target(ctrl_r.op_mode);
          end
        end
        S_WSLP, S_SLEEP, S_DEEP: begin
          if (wake_evt) begin
            state_r <= S_EXIT;
          end
        end
        S_EXIT: begin
          if (ph_done) begin
            state_r <= S_CFG;
          end
        end
      endcase
    end
  end

  // ****************************************
  // conversion phases
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      conv_r <= C_IDLE;
    end else if (mode_chg | wake_evt) begin
      conv_r <= C_IDLE; // a mode change abandons the conversion
    end else begin
      unique case (conv_r)
        C_IDLE: if (start_req) begin
          conv_r <= C_INIT;
        end
        C_INIT: if (ph_done) begin
          conv_r <= C_RUN;
        end
        C_RUN: if (ph_done) begin
          conv_r <= C_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // configuration registers
  // ****************************************
  // writes land only while awake; in sleep the frame is the wake-up
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl_r   <= opmode_pkg::CTRL_RST;
      sensor_r <= opmode_pkg::SENSOR_RST;
      wake_r   <= opmode_pkg::WAKE_RST;
      alrt_r   <= opmode_pkg::ALERT_RST;
    end else if (deep_entry) begin
      ctrl_r.trig_src <= opmode_pkg::CTRL_RST.trig_src;
      sensor_r        <= opmode_pkg::SENSOR_RST;
      wake_r          <= opmode_pkg::WAKE_RST;
      alrt_r          <= opmode_pkg::ALERT_RST;
    end else begin
      if (wr & awake) begin
        unique case (addr)
          opmode_pkg::A_CTRL:   ctrl_r   <= wdata[4:0];
          opmode_pkg::A_SENSOR: sensor_r <= wdata[9:0];
          opmode_pkg::A_WAKE:   wake_r   <= wdata[3:0];
          opmode_pkg::A_ALERT:  alrt_r   <= wdata[1:0];
          default: ;
        endcase
      end
      // hardware set after the write: waking always lands in configuration
      if (wake_evt) begin
        ctrl_r.op_mode <= opmode_pkg::OM_CFG;
      end
    end
  end

  // ****************************************
  // results
  // ****************************************
  // kept through sleep and wake-sleep, lost in deep sleep
  always_ff @(posedge clk) begin
    if (!rstn) begin
      result_r <= 16'h0000;
    end else if (deep_entry) begin
      result_r <= 16'h0000;
    end else if ((conv_r == C_RUN) & ph_done) begin
      result_r <= result_r + 16'h0001;
    end
  end

  // ****************************************
  // alert pin
  // ****************************************
  logic conv_done; // conversion just finished
  logic alert_set; // raise alert this cycle
  logic alert_clr; // status read, mode change or wake clears it
  assign conv_done = (conv_r == C_RUN) & ph_done & ~mode_chg & ~wake_evt;
  assign alert_set = conv_done & (alrt_r.thr_only ? thr_exceeded : alrt_r.on_done);
  assign alert_clr = (rd & (addr == opmode_pkg::A_STATUS)) | mode_chg | wake_evt;

  // set wins over clear so a finish in the read cycle is not lost
  always_ff @(posedge clk) begin
    if (!rstn) begin
      alert_oe <= 1'b0;
      alert_o  <= 1'b0;
      own_r    <= 4'h0;
    end else begin
      alert_o <= 1'b0; // open drain only ever pulls low
      own_r   <= {own_r[2:0], alert_oe};
      if (alert_set) begin
        alert_oe <= 1'b1;
      end else if (alert_clr) begin
        alert_oe <= 1'b0;
      end
    end
  end

  // ****************************************
  // status outputs
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      mode_code  <= opmode_pkg::OM_CFG;
      support_on <= 1'b0;
      conv_start <= 1'b0;
      conv_busy  <= 1'b0;
    end else begin
      mode_code  <= code_of(state_r, ctrl_r.op_mode);
      support_on <= (state_r == S_STBY) | (state_r == S_ACT);
      conv_start <= (conv_r == C_INIT) & ph_done & ~mode_chg & ~wake_evt;
      conv_busy  <= (conv_r != C_IDLE);
    end
  end

  // ****************************************
  // read port
  // ****************************************
  // data stand one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata <= 32'h0000_0000;
    end else if (rd) begin
      unique case (addr)
        opmode_pkg::A_CTRL:   rdata <= {27'h000_0000, ctrl_r};
        opmode_pkg::A_SENSOR: rdata <= {22'h00_0000, sensor_r};
        opmode_pkg::A_WAKE:   rdata <= {28'h000_0000, wake_r};
        opmode_pkg::A_ALERT:  rdata <= {30'h0000_0000, alrt_r};
        opmode_pkg::A_STATUS: rdata <= {26'h000_0000, alert_oe, conv_r == C_INIT,
                                        conv_r != C_IDLE, code_of(state_r, ctrl_r.op_mode)};
        opmode_pkg::A_RESULT: rdata <= {16'h0000, result_r};
        default:              rdata <= 32'h0000_0000;
      endcase
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

endmodule

// ---- test/opmode_ctrl_checker.sv ----
/* port checker for the operating-mode controller.
   assumes it is bound to opmode_ctrl and sees its ports. */
module opmode_ctrl_checker #(
  parameter int CFG_STBY_CYC = 5000
) (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic [2:0]  mode_code,
  input wire logic        support_on,
  input wire logic        conv_start,
  input wire logic        conv_busy,
  input wire logic        alert_o,
  input wire logic        alert_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int AL = opmode_pkg::ACT_INIT_US * opmode_pkg::CLK_MHZ;  // start delay from active
  localparam int SL = opmode_pkg::STBY_INIT_US * opmode_pkg::CLK_MHZ; // start delay from standby
  localparam int CL = CFG_STBY_CYC + SL;                              // start delay from cfg
  // ****
  // start delay counter: delays run to thousands of cycles, too long for a range
  // ****
  logic        trig_seen;  // trigger write taken in cfg, standby or active-triggered
  logic        armed_r;    // waiting for the start pulse
  logic [2:0]  arm_mode_r; // mode the trigger was taken in
  logic [15:0] since_r;    // cycles since that trigger, saturating
  assign trig_seen = wr && addr == opmode_pkg::A_TRIG && !conv_busy && (mode_code == opmode_pkg::OM_CFG
    || mode_code == opmode_pkg::OM_STBY || mode_code == opmode_pkg::OM_ACTT);
  always_ff @(posedge clk) begin
    if (!rstn) begin
      armed_r    <= 1'b0;
      arm_mode_r <= 3'h0;
      since_r    <= 16'h0000;
    end else if (trig_seen) begin
      armed_r    <= 1'b1;
      arm_mode_r <= mode_code;
      since_r    <= 16'h0001;
    end else begin
      if (conv_start) armed_r <= 1'b0;
      if (since_r != 16'hffff) since_r <= since_r + 16'h0001;
    end
  end
  // start must come within four cycles after lo, and a missing start fires at lo + 5
  property start_in(logic [2:0] m, int lo);
    armed_r && arm_mode_r == m && (conv_start || since_r == 16'(lo + 5))
      |-> conv_start && since_r >= 16'(lo) && since_r <= 16'(lo + 4);
  endproperty
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // ****
  // trigger write while idle in a mode
  // ****
  sequence trig_in(logic [2:0] m);
    wr && addr == opmode_pkg::A_TRIG && mode_code == m && !conv_busy;
  endsequence
  AST_RST_CFG: assert property ($rose(rstn) |-> mode_code == opmode_pkg::OM_CFG)
    else $error("mode after reset not cfg");
  AST_MODE_SEL: assert property (wr && addr == opmode_pkg::A_CTRL && wdata[2:0] == opmode_pkg::OM_STBY
    && mode_code == opmode_pkg::OM_CFG |-> ##3 mode_code == opmode_pkg::OM_STBY)
    else $error("standby not entered");
  AST_SUPPORT: assert property ($stable(mode_code) && mode_code == opmode_pkg::OM_STBY |-> support_on)
    else $error("support off in standby");
  AST_ACT_DLY: assert property (start_in(opmode_pkg::OM_ACTT, AL))
    else $error("active start delay wrong");
  AST_STBY_DLY: assert property (start_in(opmode_pkg::OM_STBY, SL))
    else $error("standby start delay wrong");
  AST_CFG_DLY: assert property (start_in(opmode_pkg::OM_CFG, CL))
    else $error("cfg start delay wrong");
  AST_TRIG_BUSY: assert property (trig_in(opmode_pkg::OM_STBY) |-> ##2 conv_busy)
    else $error("standby trigger not taken");
  AST_START_PULSE: assert property (conv_start |-> conv_busy ##1 !conv_start)
    else $error("start pulse malformed");
  AST_DEEP_NOSTART: assert property (mode_code == opmode_pkg::OM_DEEP |-> !conv_start)
    else $error("start in deep sleep");
  AST_ALERT_OD: assert property (alert_oe |-> !alert_o)
    else $error("alert driven high");
endmodule

bind opmode_ctrl opmode_ctrl_checker #(.CFG_STBY_CYC(CFG_STBY_CYC)) chk (.clk(clk), .rstn(rstn), .addr(addr),
  .wdata(wdata), .wr(wr), .mode_code(mode_code), .support_on(support_on), .conv_start(conv_start),
  .conv_busy(conv_busy), .alert_o(alert_o), .alert_oe(alert_oe));

// ---- test/host_model.sv ----
/* host side of the serial pins and the alert wire.
   assumes the bench calls its tasks; the wire has a pull-up. */
module host_model (
  // alert drive from the device
  input wire logic alert_o,
  input wire logic alert_oe,
  // pins to the device
  output logic     cs_n,
  output logic     sck,
  output logic     alert_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pull = 1'b0; // host pulling the alert wire low
  initial cs_n = 1'b1;
  initial sck = 1'b0;
  // pulled up; low while either side drives it
  assign alert_i = ((alert_oe && !alert_o) || pull) ? 1'b0 : 1'b1;
  // one frame; the serial clock stands still outside it
  task automatic frame(input int n);
    cs_n = 1'b0;
    repeat (n) begin
      #62.5 sck = 1'b1;
      #62.5 sck = 1'b0;
    end
    #60 cs_n = 1'b1;
  endtask
  task automatic wake_alert();
    pull = 1'b1;
    #200 pull = 1'b0;
  endtask
endmodule

// ---- test/hall_sensor_operating_mode_control_tb.sv ----
/* self-checking bench of the operating-mode controller.
   assumes short timing parameters so the run stays brief. */
module hall_sensor_operating_mode_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, thr_exceeded = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, v;
  logic cs_n, sck, alert_i, alert_o, alert_oe, support_on, conv_start, conv_busy;
  logic [2:0] mode_code;
  int miscompares = 0, checked = 0, cyc = 0;
  always #5 clk = ~clk;
  host_model hm (.alert_o(alert_o), .alert_oe(alert_oe), .cs_n(cs_n), .sck(sck), .alert_i(alert_i));
  opmode_ctrl #(.MS_CYC(20), .CFG_STBY_CYC(10), .SLEEP_EXIT_CYC(10)) dut (.clk(clk), .rstn(rstn),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .cs_n(cs_n), .sck(sck),
    .alert_i(alert_i), .alert_o(alert_o), .alert_oe(alert_oe), .thr_exceeded(thr_exceeded),
    .mode_code(mode_code), .support_on(support_on), .conv_start(conv_start), .conv_busy(conv_busy));
  // ****
  // compare, verdict and hang guard
  // ****
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      miscompares++;
      close_out();
    end
  end
  // ****
  // register port: one-cycle strobes, data the cycle after rd
  // ****
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic till_mode(input logic [2:0] m);
    int n;
    n = 0;
    while (mode_code !== m && n < 300) begin
      @(posedge clk);
      #1 n++;
    end
    check("mode_code", 32'(mode_code), 32'(m));
  endtask
  // ****
  // scenarios
  // ****
  task automatic sc_reset();
    rreg(opmode_pkg::A_CTRL, v);
    check("ctrl_rst", v, 32'h0000_0000);
    rreg(8'h40, v);
    check("unmapped", v, 32'h0000_0000);
    wreg(opmode_pkg::A_SENSOR, 32'h0000_0013);
    rreg(opmode_pkg::A_SENSOR, v);
    check("sensor_wr", v, 32'h0000_0013);
  endtask
  // two axes, averaging 1: conversion is 2 * 200 cycles
  task automatic run_trig(input logic [2:0] m, input int d);
    int n;
    n = 0;
    wreg(opmode_pkg::A_CTRL, 32'(m));
    till_mode(m);
    wreg(opmode_pkg::A_TRIG, 32'h0000_0001);
    while (conv_start !== 1'b1 && n < 9000) begin
      @(posedge clk);
      #1 n++;
    end
    check("start_delay", 32'(n >= d && n <= d + 4), 32'h0000_0001);
    n = 0;
    while (conv_busy !== 1'b0 && n < 900) begin
      @(posedge clk);
      #1 n++;
    end
    check("conv_time", 32'(n >= 398 && n <= 402), 32'h0000_0001);
  endtask
  task automatic sc_cont();
    int n;
    n = 0;
    wreg(opmode_pkg::A_CTRL, 32'(opmode_pkg::OM_ACTC));
    repeat (3000) begin
      @(posedge clk);
      #1 if (conv_start === 1'b1) n++;
    end
    check("cont_starts", 32'(n >= 2), 32'h0000_0001);
  endtask
  task automatic sc_sleep();
    wreg(opmode_pkg::A_CTRL, 32'(opmode_pkg::OM_SLEEP));
    till_mode(opmode_pkg::OM_SLEEP);
    hm.wake_alert();
    repeat (30) @(posedge clk);
    till_mode(opmode_pkg::OM_CFG);
    rreg(opmode_pkg::A_SENSOR, v);
    check("sensor_kept", v, 32'h0000_0013);
  endtask
  // threshold-only alert: quiet while below, raised once exceeded, cleared by a status read
  task automatic sc_thr();
    wreg(opmode_pkg::A_ALERT, 32'h0000_0002);
    run_trig(opmode_pkg::OM_CFG, 3510);
    check("thr_quiet", 32'(alert_oe), 32'h0000_0000);
    @(posedge clk);
    thr_exceeded <= 1'b1;
    run_trig(opmode_pkg::OM_CFG, 3510);
    check("thr_alert", 32'(alert_oe), 32'h0000_0001);
    rreg(opmode_pkg::A_STATUS, v);
    check("status", v, 32'h0000_0020);
    check("rd_clr", 32'(alert_oe), 32'h0000_0000);
  endtask
  task automatic sc_wsleep();
    int n;
    n = 0;
    wreg(opmode_pkg::A_ALERT, 32'h0000_0001);
    wreg(opmode_pkg::A_CTRL, 32'(opmode_pkg::OM_WSLP));
    while (alert_oe !== 1'b1 && n < 6000) begin
      @(posedge clk);
      #1 n++;
    end
    check("wake_alert", 32'(alert_oe), 32'h0000_0001);
    hm.frame(4);
    repeat (30) @(posedge clk);
    till_mode(opmode_pkg::OM_CFG);
    check("alert_clr", 32'(alert_oe), 32'h0000_0000);
  endtask
  task automatic sc_deep();
    wreg(opmode_pkg::A_CTRL, 32'(opmode_pkg::OM_DEEP));
    till_mode(opmode_pkg::OM_DEEP);
    hm.frame(2);
    repeat (30) @(posedge clk);
    till_mode(opmode_pkg::OM_CFG);
    rreg(opmode_pkg::A_SENSOR, v);
    check("sensor_dflt", v, 32'h0000_0001);
    rreg(opmode_pkg::A_RESULT, v);
    check("result_lost", v, 32'h0000_0000);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    sc_reset();
    run_trig(opmode_pkg::OM_CFG, 3510);
    run_trig(opmode_pkg::OM_STBY, 3500);
    run_trig(opmode_pkg::OM_ACTT, 1000);
    sc_cont();
    sc_sleep();
    sc_thr();
    sc_wsleep();
    sc_deep();
    close_out();
  end
endmodule
